// [core/phy_basic_mode_control_low.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_basic_mode_control_low #(
    parameter int ADDR_W = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_strap_speed_100,
    input wire logic i_strap_full_duplex,
    input wire logic i_strap_an_enable,
    input wire logic i_mgmt_valid,
    input wire port_ctrl_pkg::mgmt_req_s i_mgmt_req,
    output logic [15:0] o_mgmt_rdata,
    input wire logic i_power_down_low_pin,
    input wire port_ctrl_pkg::port_mode_s i_an_result,
    input wire logic i_an_started,
    output logic o_an_restart,
    output logic o_an_enable,
    output port_ctrl_pkg::port_mode_s o_port_mode,
    output logic o_power_down,
    output logic o_isolate,
    input wire logic i_tx_en,
    output logic o_col
);
    import port_ctrl_pkg::*;

    localparam int ASSERT_MAX = COL_ASSERT_CYCLES;
    localparam int DEASSERT_MAX = COL_DEASSERT_CYCLES;

    // Only the five-bit address field of the serial frame is decoded
    if (ADDR_W != $bits(PORT_BASIC_CONTROL_ADDR)) begin : g_addr_w_check
        $error("Management address must be 5 bits wide");
    end

    // ------------------------------------------------------------
    // Pin synchroniser for the power-down pin
    // ------------------------------------------------------------
    logic [2:0] pd_sync_r;
    logic pin_pd_r;
    logic pin_pd_nxt;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pd_sync_r <= 3'h7;
        end else begin
            pd_sync_r <= {pd_sync_r[1:0], i_power_down_low_pin};
        end
    end

    // Counts a change only once stages two and three agree
    assign pin_pd_nxt = (pd_sync_r[1] == pd_sync_r[2]) ? ~pd_sync_r[2] : pin_pd_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pin_pd_r <= 1'b0;
        end else begin
            pin_pd_r <= pin_pd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic speed_r;
    logic an_en_r;
    logic pwr_down_r;
    logic isolate_r;
    logic restart_r;
    logic duplex_r;
    logic col_test_r;
    logic hit;
    logic wr;
    logic rd;
    logic an_off_wr;
    logic pd_eff;
    logic restart_set;
    logic restart_nxt;
    logic [15:0] reg_view;

    assign hit = i_mgmt_req.addr == PORT_BASIC_CONTROL_ADDR;
    assign wr = i_mgmt_valid && i_mgmt_req.write && hit;
    assign rd = i_mgmt_valid && !i_mgmt_req.write && hit;

    assign restart_set = wr && i_mgmt_req.wdata[AN_RESTART_BIT] && i_mgmt_req.wdata[AN_EN_BIT];

    // disabling negotiation drops a pending restart in the same step
    // so the bit never reads 1 while the enable bit reads 0
    assign an_off_wr = wr && !i_mgmt_req.wdata[AN_EN_BIT];

    // zero write ignored
    // A fresh request in the cycle of the start wins over the self clear
    assign restart_nxt = restart_set ? 1'b1 : (i_an_started || an_off_wr || !an_en_r) ? 1'b0 : restart_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            speed_r <= i_strap_speed_100;
            duplex_r <= i_strap_full_duplex;
            an_en_r <= i_strap_an_enable;
            pwr_down_r <= 1'b0;
            isolate_r <= 1'b0;
            col_test_r <= 1'b0;
        end else if (wr) begin
            speed_r <= i_mgmt_req.wdata[SPEED_BIT];
            duplex_r <= i_mgmt_req.wdata[DUPLEX_BIT];
            an_en_r <= i_mgmt_req.wdata[AN_EN_BIT];
            pwr_down_r <= i_mgmt_req.wdata[PWR_DOWN_BIT];
            isolate_r <= i_mgmt_req.wdata[ISOLATE_BIT];
            col_test_r <= i_mgmt_req.wdata[COL_TEST_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= restart_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // bit or pin
    assign pd_eff = pwr_down_r | pin_pd_r;

    always_comb begin
        reg_view = RDATA_IDLE;
        reg_view[SPEED_BIT] = speed_r;
        reg_view[AN_EN_BIT] = an_en_r;
        reg_view[PWR_DOWN_BIT] = pd_eff;
        reg_view[ISOLATE_BIT] = isolate_r;
        reg_view[AN_RESTART_BIT] = restart_r;
        reg_view[DUPLEX_BIT] = duplex_r;
        reg_view[COL_TEST_BIT] = col_test_r;
    end

    // Reads are answered only in the cycle after a read strobe to this address; other cycles return RDATA_IDLE;
    // the register block stays live through power down and isolation
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_mgmt_rdata <= RDATA_IDLE;
        end else begin
            o_mgmt_rdata <= rd ? reg_view : RDATA_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Port mode and controls
    // ------------------------------------------------------------
    port_mode_s mode_nxt;

    assign mode_nxt = an_en_r ? i_an_result : port_mode_s'{speed_100: speed_r, full_duplex: duplex_r};

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_port_mode <= '0;
            o_power_down <= 1'b0;
            o_isolate <= 1'b0;
        end else begin
            o_port_mode <= mode_nxt;
            o_power_down <= pd_eff;
            o_isolate <= isolate_r;
        end
    end

    assign o_an_restart = restart_r;
    assign o_an_enable = an_en_r;

    // ------------------------------------------------------------
    // Collision test
    // ------------------------------------------------------------
    // Transmit enable comes from same-clock logic; one flop keeps both
    // edges within the 256-cycle rise and 2-cycle fall limits set by 512 and 4 bit times at 100 Mb/s
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_col <= 1'b0;
        end else begin
            o_col <= col_test_r & i_tx_en;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    property p_col_rise;
        col_test_r && $rose(i_tx_en) |-> ##[1:ASSERT_MAX] o_col;
    endproperty
    a_col_rise: assert property (p_col_rise) else $error("Collision not raised in time");

    property p_col_fall;
        col_test_r && $fell(i_tx_en) |-> ##[1:DEASSERT_MAX] !o_col;
    endproperty
    a_col_fall: assert property (p_col_fall) else $error("Collision not dropped in time");

    property p_restart_ignored;
        wr && !i_mgmt_req.wdata[AN_EN_BIT] |=> !restart_r;
    endproperty
    a_restart_ignored: assert property (p_restart_ignored) else $error("Restart taken while disabled");

    property p_restart_taken;
        restart_set |=> restart_r && o_an_restart;
    endproperty
    a_restart_taken: assert property (p_restart_taken) else $error("Restart request lost");

    property p_restart_holds;
        restart_r && !i_an_started && an_en_r && !restart_set && !an_off_wr |=> restart_r;
    endproperty
    a_restart_holds: assert property (p_restart_holds) else $error("Restart bit cleared early");

    property p_restart_zero_write;
        restart_r && wr && !i_mgmt_req.wdata[AN_RESTART_BIT] && i_mgmt_req.wdata[AN_EN_BIT]
            && !i_an_started |=> restart_r;
    endproperty
    a_restart_zero_write: assert property (p_restart_zero_write) else $error("Zero write cleared restart");

    property p_forced_mode;
        !an_en_r ##1 !an_en_r |-> o_port_mode == {$past(speed_r), $past(duplex_r)};
    endproperty
    a_forced_mode: assert property (p_forced_mode) else $error("Forced mode does not follow bits");

    property p_an_mode;
        an_en_r ##1 an_en_r |-> o_port_mode == $past(i_an_result);
    endproperty
    a_an_mode: assert property (p_an_mode) else $error("Mode bits used under negotiation");

    property p_pin_power_down;
        pin_pd_r |=> o_power_down;
    endproperty
    a_pin_power_down: assert property (p_pin_power_down) else $error("Pin did not power down");

    property p_reserved_zero;
        ##1 o_mgmt_rdata[COL_TEST_BIT-1:0] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero");

    property p_write_effect;
        wr |=> ##1 o_isolate == $past(i_mgmt_req.wdata[ISOLATE_BIT], 2);
    endproperty
    a_write_effect: assert property (p_write_effect) else $error("Isolate write not applied");

    property p_restart_cleared;
        restart_r && i_an_started && !restart_set |=> !restart_r;
    endproperty
    a_restart_cleared: assert property (p_restart_cleared) else $error("Restart bit did not self clear");

    property p_power_down_bit;
        pwr_down_r |=> o_power_down;
    endproperty
    a_power_down_bit: assert property (p_power_down_bit) else $error("Power down bit not applied");

    property p_read_power;
        rd && pd_eff |=> o_mgmt_rdata[PWR_DOWN_BIT];
    endproperty
    a_read_power: assert property (p_read_power) else $error("Power down not shown in read");

    property p_col_off;
        !col_test_r |=> !o_col;
    endproperty
    a_col_off: assert property (p_col_off) else $error("Collision raised outside test");

    property p_forced_speed;
        !an_en_r |=> o_port_mode.speed_100 == $past(speed_r);
    endproperty
    a_forced_speed: assert property (p_forced_speed) else $error("Forced speed does not follow bit");

    c_col_test: cover property (col_test_r && $rose(i_tx_en) ##[1:2] o_col);
    c_restart_done: cover property (restart_r ##1 i_an_started ##1 !restart_r);
    c_forced_100_full: cover property (!an_en_r && o_port_mode.speed_100 && o_port_mode.full_duplex);
    c_pin_down: cover property ($rose(pin_pd_r));
    c_enable_drops_restart: cover property (restart_r && an_off_wr ##1 !restart_r);
endmodule
`default_nettype wire

// [core/port_ctrl_pkg.sv]
package port_ctrl_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] PORT_BASIC_CONTROL_ADDR = 5'h00;
    localparam int SPEED_BIT = 13;
    localparam int AN_EN_BIT = 12;
    localparam int PWR_DOWN_BIT = 11;
    localparam int ISOLATE_BIT = 10;
    localparam int AN_RESTART_BIT = 9;
    localparam int DUPLEX_BIT = 8;
    localparam int COL_TEST_BIT = 7;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    // ------------------------------------------------------------
    // Collision test timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_TIME_NS = 10;
    localparam int COL_ASSERT_BIT_TIMES = 512;
    localparam int COL_DEASSERT_BIT_TIMES = 4;
    // Longest times round down; the faster bit rate is the binding one
    localparam int COL_ASSERT_CYCLES = COL_ASSERT_BIT_TIMES * BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int COL_DEASSERT_CYCLES = COL_DEASSERT_BIT_TIMES * BIT_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } port_mode_s;

    typedef struct packed {
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_s;
endpackage

// [sim/an_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module an_engine_model
    import port_ctrl_pkg::*;
#(
    parameter int DELAY = 3,
    parameter logic [1:0] RESULT = 2'b01
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_restart,
    input wire logic i_stall,
    output logic o_started,
    output port_ctrl_pkg::port_mode_s o_result
);
    logic [7:0] wait_r;

    assign o_result = port_mode_s'(RESULT);

    // ------------------------------------------------------------
    // Negotiation start handshake
    // ------------------------------------------------------------
    // start reported after a delay
    always_ff @(posedge i_clk_sys) begin
        o_started <= 1'b0;
        if (i_reset || !i_restart || i_stall || o_started) begin
            wait_r <= 8'h00;
        end else if (wait_r == 8'(DELAY)) begin
            o_started <= 1'b1;
            wait_r <= 8'h00;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import port_ctrl_pkg::*;
    typedef struct packed {
        logic [15:0] wdata;
        logic [15:0] rexp;
        logic [4:0] outs;
    } row_s;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic s_speed = 1'b1;
    logic s_dup = 1'b0;
    logic s_an = 1'b1;
    logic valid = 1'b0;
    mgmt_req_s req = '0;
    logic [15:0] rdata;
    logic pin_n = 1'b1;
    port_mode_s an_result;
    logic an_started;
    logic an_restart;
    logic an_enable;
    port_mode_s mode;
    logic pwr;
    logic iso;
    logic tx_en = 1'b0;
    logic col;
    logic stall = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    row_s rows [6] = '{
        '{16'h2100, 16'h2100, 5'h03}, '{16'h007f, 16'h0000, 5'h00},
        '{16'h2000, 16'h2000, 5'h02}, '{16'h0300, 16'h0100, 5'h01},
        '{16'h0c00, 16'h0c00, 5'h0c}, '{16'h3100, 16'h3100, 5'h11}};

    always #10 clk_sys = ~clk_sys;

    phy_basic_mode_control_low phy_basic_mode_control_low_i (.i_clk_sys(clk_sys), .i_reset(reset),
        .i_strap_speed_100(s_speed), .i_strap_full_duplex(s_dup), .i_strap_an_enable(s_an),
        .i_mgmt_valid(valid), .i_mgmt_req(req), .o_mgmt_rdata(rdata), .i_power_down_low_pin(pin_n),
        .i_an_result(an_result), .i_an_started(an_started), .o_an_restart(an_restart),
        .o_an_enable(an_enable), .o_port_mode(mode), .o_power_down(pwr), .o_isolate(iso),
        .i_tx_en(tx_en), .o_col(col));
    an_engine_model an_engine_model_i (.i_clk_sys(clk_sys), .i_reset(reset), .i_restart(an_restart),
        .i_stall(stall), .o_started(an_started), .o_result(an_result));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Each access leaves one idle cycle so the strobe is never rewritten in one step
    task automatic wr(input logic [15:0] d, input logic [4:0] a = PORT_BASIC_CONTROL_ADDR);
        valid = 1'b1;
        req = '{write: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        valid = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd_chk(input logic [15:0] exp, input logic [4:0] a = PORT_BASIC_CONTROL_ADDR);
        valid = 1'b1;
        req = '{write: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clk_sys);
        valid = 1'b0;
        check("rdata", rdata, exp);
        @(negedge clk_sys);
    endtask

    function automatic logic [15:0] outs();
        return {11'h000, an_enable, pwr, iso, mode};
    endfunction

    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        rd_chk(16'h3000);
        check("outs", outs(), 16'h0011);
        foreach (rows[i]) begin
            wr(rows[i].wdata);
            check("outs", outs(), {11'h000, rows[i].outs});
            rd_chk(rows[i].rexp);
        end
        stall = 1'b1;
        wr(16'h3300);
        check("restart", {15'h0, an_restart}, 16'h0001);
        rd_chk(16'h3300);
        wr(16'h3100);
        rd_chk(16'h3300);
        stall = 1'b0;
        for (int n = 0; n < 20 && an_restart !== 1'b0; n++) begin
            @(negedge clk_sys);
        end
        rd_chk(16'h3100);
        wr(16'h0000, 5'h01);
        rd_chk(16'h3100);
        rd_chk(16'h0000, 5'h01);
        stall = 1'b1;
        wr(16'h3300);
        wr(16'h2100);
        check("restart", {15'h0, an_restart}, 16'h0000);
        rd_chk(16'h2100);
        stall = 1'b0;
        wr(16'h3100);
        pin_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        check("power", {15'h0, pwr}, 16'h0001);
        rd_chk(16'h3900);
        pin_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("power", {15'h0, pwr}, 16'h0000);
        wr(16'h3180);
        tx_en = 1'b1;
        @(negedge clk_sys);
        check("col", {15'h0, col}, 16'h0001);
        tx_en = 1'b0;
        @(negedge clk_sys);
        check("col", {15'h0, col}, 16'h0000);
        wr(16'h3100);
        tx_en = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("col", {15'h0, col}, 16'h0000);
        tx_en = 1'b0;
        {s_speed, s_dup, s_an} = 3'b010;
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        repeat (2) @(negedge clk_sys);
        rd_chk(16'h0100);
        check("outs", outs(), 16'h0001);
        end_of_test();
    end
endmodule
`default_nettype wire
